// ===== verilog/link_watchdog_pkg.sv
// constants and types shared by the link watchdog design
// Function
// - clear all images after 1 s silence
// - robot-side outputs zero while power link idle
// - address from units and tens switches
// - up to 64 nodes on one line
package link_watchdog_pkg;
  localparam int unsigned CLOCK_HZ = 50000000;
  localparam int unsigned TIMEOUT_MS = 1000;
  localparam int unsigned TIMEOUT_CYCLES = CLOCK_HZ / 1000 * TIMEOUT_MS;
  localparam int unsigned LINK_BITRATE = 500000;
  localparam int unsigned MAX_NODES = 64;
  localparam int unsigned ADDR_WIDTH = 6;
  localparam int unsigned IMAGE_WIDTH = 32;
  localparam int unsigned COUNT_WIDTH = 26;
  localparam logic [IMAGE_WIDTH-1:0] IMAGE_RESET = 32'h00000000;
  localparam logic [3:0] DIGIT_MAX = 4'h9;
  localparam logic [ADDR_WIDTH-1:0] TENS_WEIGHT = 6'h0A;
  localparam logic [ADDR_WIDTH-1:0] ADDR_LIMIT = 6'h3F;

  typedef enum logic [1:0] {
    WD_IDLE = 2'b00,
    WD_ALIVE = 2'b01,
    WD_EXPIRED = 2'b10
  } wd_state_t;
endpackage

// ===== verilog/silence_if.sv
// timer request and expiry signals between watchdog and its timer
`timescale 1ns/1ps
`default_nettype none
interface silence_if;
  logic restart;
  logic expired;
  modport owner (output restart, input expired);
  modport timer (input restart, output expired);
endinterface
`default_nettype wire

// ===== verilog/silence_timer.sv
// silence timer that expires after an uninterrupted quiet interval
`timescale 1ns/1ps
`default_nettype none
module silence_timer
  import link_watchdog_pkg::*;
#(
  parameter logic [COUNT_WIDTH-1:0] LIMIT = COUNT_WIDTH'(TIMEOUT_CYCLES)
) (
  input wire logic i_clock,
  input wire logic i_nrst,
  silence_if.timer link
);
  typedef struct packed {
    logic [COUNT_WIDTH-1:0] count;
    logic expired;
  } timer_state_t;
  timer_state_t state, next_state;

  always_comb begin
    next_state = state;
    if (link.restart) begin
      next_state.count = '0;
      next_state.expired = 1'b0;
    end else if (state.count >= LIMIT - 1'b1) begin
      next_state.expired = 1'b1;
    end else begin
      next_state.count = state.count + 1'b1;
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign link.expired = state.expired;

  a_timer_restart: assert property (@(posedge i_clock) disable iff (!i_nrst)
    link.restart |=> !link.expired && state.count == '0) else $error("restart ignored");
endmodule // silence_timer
`default_nettype wire

// ===== verilog/fieldbus_link_watchdog.sv
// link supervision between robot fieldbus and power source link
`timescale 1ns/1ps
`default_nettype none
module fieldbus_link_watchdog
  import link_watchdog_pkg::*;
#(
  parameter logic [COUNT_WIDTH-1:0] TIMEOUT_LIMIT = COUNT_WIDTH'(TIMEOUT_CYCLES)
) (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_rx_valid,
  input wire logic [IMAGE_WIDTH-1:0] i_rx_data,
  input wire logic [IMAGE_WIDTH-1:0] i_ps_data,
  input wire logic i_ps_active,
  input wire logic [3:0] i_units_digit_switch,
  input wire logic [3:0] i_tens_digit_switch,
  output logic [IMAGE_WIDTH-1:0] o_ps_image,
  output logic [IMAGE_WIDTH-1:0] o_robot_image,
  output logic [ADDR_WIDTH-1:0] o_node_address,
  output logic o_address_valid,
  output logic o_link_timeout,
  output logic o_link_alive
);
  typedef struct packed {
    wd_state_t mode;
    logic [IMAGE_WIDTH-1:0] ps_image;
    logic [IMAGE_WIDTH-1:0] robot_image;
    logic [ADDR_WIDTH-1:0] address;
    logic address_valid;
    logic address_taken;
  } wd_t;
  wd_t state, next_state;

  silence_if timer_link ();

  silence_timer #(
    .LIMIT(TIMEOUT_LIMIT)
  ) u_timer (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .link(timer_link)
  );

  assign timer_link.restart = i_rx_valid;

  logic [ADDR_WIDTH-1:0] switch_address;
  logic [7:0] wide_address;
  logic switch_ok;
  // sum kept wide so an address above the node limit cannot wrap back in range
  always_comb begin
    wide_address = 8'(i_tens_digit_switch) * 8'(TENS_WEIGHT)
      + 8'(i_units_digit_switch);
    switch_address = wide_address[ADDR_WIDTH-1:0];
    switch_ok = i_units_digit_switch <= DIGIT_MAX && i_tens_digit_switch <= DIGIT_MAX
      && wide_address <= 8'(ADDR_LIMIT);
  end

  always_comb begin
    next_state = state;
    if (!state.address_taken) begin
      next_state.address = switch_address;
      next_state.address_valid = switch_ok;
      next_state.address_taken = 1'b1;
    end
    unique case (state.mode)
      WD_IDLE: begin
        if (i_rx_valid) begin
          next_state.mode = WD_ALIVE;
        end
      end
      WD_ALIVE: begin
        if (timer_link.expired && !i_rx_valid) begin
          next_state.mode = WD_EXPIRED;
        end
      end
      WD_EXPIRED: begin
        if (i_rx_valid) begin
          next_state.mode = WD_ALIVE;
        end
      end
      default: next_state.mode = WD_IDLE;
    endcase
    if (i_rx_valid) begin
      next_state.ps_image = i_rx_data;
    end
    next_state.robot_image = i_ps_active ? i_ps_data : IMAGE_RESET;
    if (timer_link.expired && !i_rx_valid) begin
      next_state.ps_image = IMAGE_RESET;
      next_state.robot_image = IMAGE_RESET;
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      state <= '{mode: WD_IDLE, ps_image: IMAGE_RESET, robot_image: IMAGE_RESET,
                 address: '0, address_valid: 1'b0, address_taken: 1'b0};
    end else begin
      state <= next_state;
    end
  end

  assign o_ps_image = state.ps_image;
  assign o_robot_image = state.robot_image;
  assign o_node_address = state.address;
  assign o_address_valid = state.address_valid;
  assign o_link_timeout = state.mode == WD_EXPIRED;
  assign o_link_alive = state.mode == WD_ALIVE;

  sequence s_silent_expiry;
    timer_link.expired && !i_rx_valid;
  endsequence

  a_images_cleared: assert property (@(posedge i_clock) disable iff (!i_nrst)
    s_silent_expiry |=> o_ps_image == IMAGE_RESET && o_robot_image == IMAGE_RESET)
    else $error("images not cleared on timeout");
  a_timeout_state: assert property (@(posedge i_clock) disable iff (!i_nrst)
    s_silent_expiry and state.mode == WD_ALIVE |=> o_link_timeout)
    else $error("timeout not flagged");
  a_robot_zero: assert property (@(posedge i_clock) disable iff (!i_nrst)
    !i_ps_active |=> o_robot_image == IMAGE_RESET) else $error("robot outputs not zero");
  a_robot_pass: assert property (@(posedge i_clock) disable iff (!i_nrst)
    i_ps_active && !(timer_link.expired && !i_rx_valid) |=> o_robot_image == $past(i_ps_data))
    else $error("robot image stale");
  a_rx_capture: assert property (@(posedge i_clock) disable iff (!i_nrst)
    i_rx_valid |=> o_ps_image == $past(i_rx_data) && !o_link_timeout)
    else $error("received data not captured");
  a_address_form: assert property (@(posedge i_clock) disable iff (!i_nrst)
    !state.address_taken |=> o_node_address == $past(switch_address))
    else $error("address not formed from switches");
  a_address_range: assert property (@(posedge i_clock) disable iff (!i_nrst)
    $rose(state.address_taken) && o_address_valid |-> 8'($past(i_tens_digit_switch))
    * 8'(TENS_WEIGHT) + 8'($past(i_units_digit_switch)) < 8'(MAX_NODES))
    else $error("address out of range");
  a_address_hold: assert property (@(posedge i_clock) disable iff (!i_nrst)
    state.address_taken |=> $stable(o_node_address)) else $error("address changed");

  // switch capture: validity must follow the digits that were read
  a_digit_range: assert property (@(posedge i_clock) disable iff (!i_nrst)
    $rose(state.address_taken) && o_address_valid |-> $past(i_tens_digit_switch) <= DIGIT_MAX
    && $past(i_units_digit_switch) <= DIGIT_MAX)
    else $error("valid address from a bad digit");

  a_invalid_reason: assert property (@(posedge i_clock) disable iff (!i_nrst)
    $rose(state.address_taken) && !o_address_valid |-> $past(i_tens_digit_switch) > DIGIT_MAX
    || $past(i_units_digit_switch) > DIGIT_MAX || 8'($past(i_tens_digit_switch))
    * 8'(TENS_WEIGHT) + 8'($past(i_units_digit_switch)) >= 8'(MAX_NODES))
    else $error("good address flagged invalid");

  a_taken_once: assert property (@(posedge i_clock) disable iff (!i_nrst)
    state.address_taken |=> state.address_taken)
    else $error("address capture repeated");

  // link supervision steps
  sequence s_rearm;
    o_link_timeout && i_rx_valid;
  endsequence

  sequence s_quiet_expired;
    o_link_timeout && !i_rx_valid;
  endsequence

  sequence s_first_transfer;
    state.mode == WD_IDLE && i_rx_valid;
  endsequence

  sequence s_quiet_alive;
    o_link_alive && !timer_link.expired;
  endsequence

  a_first_alive: assert property (@(posedge i_clock) disable iff (!i_nrst)
    s_first_transfer |=> o_link_alive)
    else $error("first transfer not marked alive");

  a_idle_wait: assert property (@(posedge i_clock) disable iff (!i_nrst)
    state.mode == WD_IDLE && !i_rx_valid |=> !o_link_alive && !o_link_timeout)
    else $error("idle left without traffic");

  a_rearm_alive: assert property (@(posedge i_clock) disable iff (!i_nrst)
    s_rearm |=> o_link_alive && !o_link_timeout)
    else $error("traffic did not end timeout");

  a_rearm_data: assert property (@(posedge i_clock) disable iff (!i_nrst)
    s_rearm |=> o_ps_image == $past(i_rx_data))
    else $error("data lost on rearm");

  a_timer_rearm: assert property (@(posedge i_clock) disable iff (!i_nrst)
    s_rearm |=> !timer_link.expired)
    else $error("timer still expired after traffic");

  a_expiry_holds: assert property (@(posedge i_clock) disable iff (!i_nrst)
    s_quiet_expired |=> o_link_timeout)
    else $error("timeout dropped while silent");

  a_quiet_ps_clear: assert property (@(posedge i_clock) disable iff (!i_nrst)
    s_quiet_expired |=> o_ps_image == IMAGE_RESET)
    else $error("ps image set while silent");

  a_quiet_robot_clear: assert property (@(posedge i_clock) disable iff (!i_nrst)
    s_quiet_expired |=> o_robot_image == IMAGE_RESET)
    else $error("robot image set while silent");

  a_ps_hold: assert property (@(posedge i_clock) disable iff (!i_nrst)
    !i_rx_valid && !timer_link.expired |=> $stable(o_ps_image))
    else $error("ps image changed without transfer");

  a_alive_holds: assert property (@(posedge i_clock) disable iff (!i_nrst)
    s_quiet_alive |=> o_link_alive)
    else $error("alive dropped before expiry");
endmodule // fieldbus_link_watchdog
`default_nettype wire

// ===== verification/robot_master_model.sv
// robot-side master model issuing fieldbus transfers
`timescale 1ns/1ps
`default_nettype none
module robot_master_model
  import link_watchdog_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_send,
  input wire logic [IMAGE_WIDTH-1:0] i_word,
  output logic o_rx_valid,
  output logic [IMAGE_WIDTH-1:0] o_rx_data
);
  logic [IMAGE_WIDTH-1:0] junk = 32'h5A5A5A5A;
  // idle data changes every cycle so a stale word never matches
  always @(negedge i_clock) begin
    junk <= ~junk;
  end
  // one word per clock for as long as i_send is high
  assign o_rx_valid = i_send;
  assign o_rx_data = i_send ? i_word : junk;
endmodule // robot_master_model
`default_nettype wire

// ===== verification/fieldbus_link_watchdog_tb_top.sv
// self-checking bench for the link watchdog
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b, m) begin num_checks++; if ((a) !== (b)) begin n_errors++; \
  $display("wrong value at %0t: %s", $time, m); end end
module fieldbus_link_watchdog_tb_top;
  import link_watchdog_pkg::*;
  localparam int LIM = 20;
  logic clk = 0, nrst = 0, send = 0, act = 0, rxv, sent = 0, av, tmo, alv;
  logic [31:0] word = '0, psd = '0, rxd, psi, rbi, d;
  logic [3:0] un = 4'h5, tn = 4'h0;
  logic [5:0] adr;
  logic [31:0] q[$];
  int n_errors = 0, num_checks = 0;
  initial forever #10 clk = ~clk;
  robot_master_model partner (.i_clock(clk), .i_send(send), .i_word(word),
    .o_rx_valid(rxv), .o_rx_data(rxd));
  fieldbus_link_watchdog #(.TIMEOUT_LIMIT(26'(LIM))) dut (.i_clock(clk), .i_nrst(nrst),
    .i_rx_valid(rxv), .i_rx_data(rxd), .i_ps_data(psd), .i_ps_active(act),
    .i_units_digit_switch(un), .i_tens_digit_switch(tn), .o_ps_image(psi),
    .o_robot_image(rbi), .o_node_address(adr), .o_address_valid(av),
    .o_link_timeout(tmo), .o_link_alive(alv));
  always @(posedge clk) sent <= rxv;
  always @(negedge clk) if (sent) begin
    d = q.pop_front();
    `CHK(psi, d, "ps image")
  end
  task wrap_up;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task rst(input logic [3:0] t, input logic [3:0] u, input logic v);
    @(negedge clk);
    nrst = 0;
    tn = t;
    un = u;
    repeat (6) @(negedge clk);
    nrst = 1;
    @(negedge clk);
    `CHK(adr, 6'(t * 10 + u), "address")
    `CHK(av, v, "address valid")
  endtask
  task xfer(input int n);
    for (int k = 0; k < n; k++) begin
      @(negedge clk);
      send = 1;
      word = $urandom;
      q.push_back(word);
    end
    @(negedge clk);
    send = 0;
  endtask
  initial begin
    int i;
    void'($urandom(32'hF2142994));
    rst(4'h6, 4'h3, 1'b1);
    rst(4'h6, 4'h9, 1'b0);
    rst(4'h0, 4'h5, 1'b1);
    un = 4'h7;
    @(negedge clk);
    `CHK(adr, 6'h05, "address held")
    un = 4'h5;
    xfer(3);
    `CHK(alv, 1'b1, "alive")
    psd = $urandom;
    act = 1;
    repeat (2) @(negedge clk);
    `CHK(rbi, psd, "robot image")
    act = 0;
    repeat (2) @(negedge clk);
    `CHK(rbi, 32'h0, "robot image idle")
    act = 1;
    repeat (3) begin
      repeat (LIM - 5) @(negedge clk);
      xfer(1);
    end
    repeat (LIM - 3) @(negedge clk);
    `CHK(tmo, 1'b0, "early timeout")
    for (i = 0; i < 10 && tmo !== 1'b1; i++) @(negedge clk);
    `CHK(tmo, 1'b1, "timeout")
    if (tmo !== 1'b1) wrap_up;
    @(negedge clk);
    `CHK(psi, 32'h0, "ps image cleared")
    `CHK(rbi, 32'h0, "robot image cleared")
    `CHK(psi, IMAGE_RESET, "default state")
    `CHK(alv, 1'b0, "alive after timeout")
    xfer(1);
    `CHK(alv, 1'b1, "alive again")
    `CHK(tmo, 1'b0, "timeout cleared")
    wrap_up;
  end
endmodule // fieldbus_link_watchdog_tb_top
`default_nettype wire
